// ### inc/fsmc_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb word per register; offsets are register indexes, byte address is four times
`ifndef FSMC_MAP_SVH
`define FSMC_MAP_SVH
`define FSMC_OFF_CONFIG      10'h000
`define FSMC_OFF_TACH_READ   10'h008
`define FSMC_OFF_TACH_TARGET 10'h010
`define FSMC_OFF_FAN_CHAR    10'h020
`define FSMC_OFF_DUTY_CODE   10'h022
`define FSMC_OFF_FILTER      10'h023
`define FSMC_OFF_AUTO_DUTY   10'h030
`define FSMC_OFF_IRQ_STATUS  10'h034
`define FSMC_OFF_IRQ_MASK    10'h038
`define FSMC_BIT_AUTO        7
`define FSMC_BIT_RPM_MODE    5
`define FSMC_BIT_INVERT      3
`define FSMC_BIT_FILTER_EN   0
`define FSMC_RST_CONFIG      8'h00
`define FSMC_RST_TARGET      8'hFF
`define FSMC_RST_FAN_CHAR    8'h40
`define FSMC_RST_DUTY_CODE   8'h0F
`define FSMC_RST_FILTER      8'h10
`define FSMC_SLOTS           8'hF0
`define FSMC_SLOTS_PER_CODE  8'h10
`define FSMC_COUNT_MAX       8'hFF
`define FSMC_IRQ_FAIL        0
`define FSMC_IRQ_DONE        1
`define FSMC_CLK_HZ          125000000
`define FSMC_OSC_HZ          11250
`define FSMC_OSC_CYC         (`FSMC_CLK_HZ / `FSMC_OSC_HZ)
`define FSMC_SLOT_NS         40
`define FSMC_SLOT_CYC        (`FSMC_SLOT_NS / 8)
`endif

// ### inc/fsmc_pkg.sv
// types shared by the fan speed mode control block
// assumes fsmc_map.svh for numbers
package fsmc_pkg;
    typedef enum logic [2:0] {
        FSMC_WAIT1 = 3'b001,
        FSMC_WAIT2 = 3'b010,
        FSMC_COUNT = 3'b100
    } fsmc_meas_t;
endpackage : fsmc_pkg

// ### rtl/fsmc_top.sv
// fan drive mode control: pwm generator, tach period counter, rpm loop, apb slave
// assumes apb master on pclk; tach input is asynchronous to pclk
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "fsmc_map.svh"
module fsmc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fan_speed_sense_input,
    output logic             pwm_out,
    output logic             fan_fail,
    output logic             irq
);
    // registers
    logic [7:0] config_one;
    logic [7:0] tach_target_limit;
    logic [7:0] fan_char;
    logic [7:0] duty_code_select;
    logic [7:0] filter_cfg;
    logic [7:0] auto_duty;
    logic [7:0] tach_reading;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // apb decode: byte address is four times the register index
    function automatic logic [11:0] fsmc_addr(input logic [9:0] idx);
        fsmc_addr = {idx, 2'b00};
    endfunction : fsmc_addr

    function automatic logic fsmc_hit(input logic [11:0] a, input logic [9:0] idx);
        fsmc_hit = a == fsmc_addr(idx);
    endfunction : fsmc_hit

    wire        wr_en    = psel & penable & pwrite;
    wire        rd_setup = psel & ~penable & ~pwrite;
    wire        hit_cfg  = fsmc_hit(paddr, `FSMC_OFF_CONFIG);
    wire        hit_rd   = fsmc_hit(paddr, `FSMC_OFF_TACH_READ);
    wire        hit_tgt  = fsmc_hit(paddr, `FSMC_OFF_TACH_TARGET);
    wire        hit_chr  = fsmc_hit(paddr, `FSMC_OFF_FAN_CHAR);
    wire        hit_dut  = fsmc_hit(paddr, `FSMC_OFF_DUTY_CODE);
    wire        hit_flt  = fsmc_hit(paddr, `FSMC_OFF_FILTER);
    wire        hit_aut  = fsmc_hit(paddr, `FSMC_OFF_AUTO_DUTY);
    wire        hit_sts  = fsmc_hit(paddr, `FSMC_OFF_IRQ_STATUS);
    wire        hit_msk  = fsmc_hit(paddr, `FSMC_OFF_IRQ_MASK);
    wire        hit_any  = hit_cfg | hit_rd | hit_tgt | hit_chr | hit_dut |
                           hit_flt | hit_aut | hit_sts | hit_msk;
    wire [7:0]  rd_byte  = hit_cfg ? config_one :
                           hit_rd  ? tach_reading :
                           hit_tgt ? tach_target_limit :
                           hit_chr ? fan_char :
                           hit_dut ? duty_code_select :
                           hit_flt ? filter_cfg :
                           hit_aut ? auto_duty :
                           hit_sts ? {6'h00, irq_status} :
                           hit_msk ? {6'h00, irq_mask} :
                           8'h00;

    // zero wait states; unmapped access flagged in access phase
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // read data latched in setup cycle, stands through access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    // register writes in access phase

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_one        <= `FSMC_RST_CONFIG;
            tach_target_limit <= `FSMC_RST_TARGET;
            fan_char          <= `FSMC_RST_FAN_CHAR;
            duty_code_select  <= `FSMC_RST_DUTY_CODE;
            filter_cfg        <= `FSMC_RST_FILTER;
            auto_duty         <= 8'h00;
            irq_mask          <= 2'h0;
        end else if (wr_en) begin
            if (hit_cfg) begin
                config_one <= pwdata[7:0];
            end
            if (hit_tgt) begin
                tach_target_limit <= pwdata[7:0];
            end
            if (hit_chr) begin
                fan_char <= pwdata[7:0];
            end
            if (hit_dut) begin
                duty_code_select <= pwdata[7:0];
            end
            if (hit_flt) begin
                filter_cfg <= pwdata[7:0];
            end
            if (hit_aut) begin
                auto_duty <= pwdata[7:0];
            end
            if (hit_msk) begin
                irq_mask <= pwdata[1:0];
            end
        end
    end

    // tach synchroniser and edge
    logic sense_s1;
    logic sense_s2;
    logic sense_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_s1 <= 1'b1;
            sense_s2 <= 1'b1;
            sense_d  <= 1'b1;
        end else begin
            sense_s1 <= fan_speed_sense_input;
            sense_s2 <= sense_s1;
            sense_d  <= sense_s2;
        end
    end
    wire tach_rise = sense_s2 & ~sense_d;

    // counting oscillator divided by speed range
    logic [13:0] osc_cnt;
    logic [2:0]  range_cnt;
    wire         osc_tick = osc_cnt == 14'(`FSMC_OSC_CYC - 1);
    wire [2:0]   range_max = 3'((1 << fan_char[7:6]) - 1);
    wire         cnt_tick = osc_tick & (range_cnt >= range_max);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt   <= 14'h0000;
            range_cnt <= 3'h0;
        end else begin
            osc_cnt <= osc_tick ? 14'h0000 : osc_cnt + 14'h0001;
            if (osc_tick) begin
                range_cnt <= cnt_tick ? 3'h0 : range_cnt + 3'h1;
            end
        end
    end

    // period measurement: second to fourth tach rise
    fsmc_pkg::fsmc_meas_t meas;
    fsmc_pkg::fsmc_meas_t next_meas;
    logic [7:0] meas_cnt;
    logic [1:0] rise_cnt;
    wire        overrange = cnt_tick & (meas_cnt == `FSMC_COUNT_MAX);
    wire        meas_done = (meas == fsmc_pkg::FSMC_COUNT) & ((tach_rise & rise_cnt == 2'h1) | overrange);
    wire [7:0]  meas_val  = overrange ? `FSMC_COUNT_MAX : meas_cnt;
    always_comb begin
        case (meas)
            fsmc_pkg::FSMC_WAIT1: next_meas = tach_rise ? fsmc_pkg::FSMC_WAIT2 : fsmc_pkg::FSMC_WAIT1;
            fsmc_pkg::FSMC_WAIT2: next_meas = tach_rise ? fsmc_pkg::FSMC_COUNT : fsmc_pkg::FSMC_WAIT2;
            fsmc_pkg::FSMC_COUNT: next_meas = meas_done ? fsmc_pkg::FSMC_WAIT1 : fsmc_pkg::FSMC_COUNT;
            default:              next_meas = fsmc_pkg::FSMC_WAIT1;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas         <= fsmc_pkg::FSMC_WAIT1;
            meas_cnt     <= 8'h00;
            rise_cnt     <= 2'h0;
            tach_reading <= 8'h00;
        end else begin
            meas <= next_meas;
            if (meas != fsmc_pkg::FSMC_COUNT) begin
                meas_cnt <= 8'h00;
                rise_cnt <= 2'h0;
            end else begin
                if (cnt_tick && meas_cnt != `FSMC_COUNT_MAX) begin
                    meas_cnt <= meas_cnt + 8'h01;
                end
                if (tach_rise) begin
                    rise_cnt <= rise_cnt + 2'h1;
                end
            end
            if (meas_done) begin
                tach_reading <= meas_val;
            end
        end
    end

    // fan failure only at full count
    wire fail_event = meas_done & (meas_val == `FSMC_COUNT_MAX);

    // pwm time slots and period
    logic [2:0] slot_div;
    logic [7:0] slot;
    wire        slot_tick  = slot_div == 3'(`FSMC_SLOT_CYC - 1);
    wire        period_end = slot_tick & (slot == `FSMC_SLOTS - 8'h01);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_div <= 3'h0;
            slot     <= 8'h00;
        end else begin
            slot_div <= slot_tick ? 3'h0 : slot_div + 3'h1;
            if (slot_tick) begin
                slot <= period_end ? 8'h00 : slot + 8'h01;
            end
        end
    end

    // rpm feedback and filtered ramp duty, in slots
    function automatic logic [7:0] fsmc_step(input logic [7:0] cur, input logic [7:0] goal, input logic [7:0] amt);
        logic [8:0] up;
        up = {1'b0, cur} + {1'b0, amt};
        if (goal > cur) begin
            fsmc_step = (up > {1'b0, goal}) ? goal : up[7:0];
        end else if (goal < cur) begin
            fsmc_step = (cur - goal < amt) ? goal : cur - amt;
        end else begin
            fsmc_step = cur;
        end
    endfunction : fsmc_step

    wire        auto_mode = config_one[`FSMC_BIT_AUTO];
    wire        rpm_mode  = config_one[`FSMC_BIT_RPM_MODE];
    wire [7:0]  ramp_amt  = 8'(1 << filter_cfg[6:5]);
    wire [7:0]  code_duty = 8'(duty_code_select[3:0] * `FSMC_SLOTS_PER_CODE);
    logic [7:0] rpm_duty;
    logic [7:0] filt_duty;
    logic [7:0] duty_now;
    logic [30:0] upd_cnt;
    wire [30:0] upd_max  = 31'(`FSMC_CLK_HZ / 8) << (3'h7 - filter_cfg[4:2]);
    wire        upd_tick = upd_cnt >= upd_max;
    wire [7:0]  auto_goal = auto_duty > `FSMC_SLOTS ? `FSMC_SLOTS : auto_duty;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpm_duty  <= `FSMC_SLOTS;
            filt_duty <= 8'h00;
            upd_cnt   <= 31'h00000000;
        end else begin
            upd_cnt <= upd_tick ? 31'h00000000 : upd_cnt + 31'h00000001;
            // one slot per measurement; slow fans below the loop's range may not settle
            if (meas_done && rpm_mode && !auto_mode) begin
                if (meas_val > tach_target_limit) begin
                    rpm_duty <= fsmc_step(rpm_duty, `FSMC_SLOTS, 8'h01);
                end else if (meas_val < tach_target_limit) begin
                    rpm_duty <= fsmc_step(rpm_duty, 8'h00, 8'h01);
                end
            end
            if (upd_tick) begin
                filt_duty <= fsmc_step(filt_duty, auto_goal, ramp_amt);
            end
        end
    end

    // mode selection of the next period's duty
    wire [7:0] auto_sel   = filter_cfg[`FSMC_BIT_FILTER_EN] ? filt_duty : auto_goal;
    wire [7:0] manual_sel = rpm_mode ? rpm_duty : code_duty;
    wire [7:0] sel_duty   = auto_mode ? auto_sel : manual_sel;
    wire       pwm_level  = (slot < duty_now) ^ config_one[`FSMC_BIT_INVERT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_now <= `FSMC_SLOTS;
            pwm_out  <= 1'b0;
        end else begin
            if (period_end) begin
                duty_now <= sel_duty;
            end
            pwm_out <= pwm_level;
        end
    end

    // interrupts: sticky, write one to clear, set wins
    wire [1:0] irq_set = {meas_done, fail_event};
    wire [1:0] irq_clr = (wr_en & hit_sts) ? pwdata[1:0] : 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
            fan_fail   <= 1'b0;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (meas_done) begin
                fan_fail <= fail_event;
            end
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule : fsmc_top

// ### verif/fsmc_checker.sv
// checker: apb answers, pwm period and slot timing, interrupt masking
// assumes bind onto fsmc_top, one pclk domain
`timescale 1ns/100ps
module fsmc_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fan_speed_sense_input,
    input wire logic        pwm_out,
    input wire logic        fan_fail,
    input wire logic        irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic mapped = paddr inside {12'h000, 12'h020, 12'h040, 12'h080, 12'h088, 12'h08C, 12'h0C0, 12'h0D0, 12'h0E0};
    wire logic mask_wr = psel && penable && pwrite && paddr == 12'h0E0;
    logic [1:0]  mask_sh;
    logic [10:0] per_cnt;
    logic [2:0]  hi_mod;
    logic        seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_sh <= 2'h0;
            per_cnt <= 11'h000;
            hi_mod  <= 3'h0;
            seen    <= 1'b0;
        end else begin
            if (mask_wr) mask_sh <= pwdata[1:0];
            per_cnt <= $rose(pwm_out) ? 11'h001 : (per_cnt == 11'h4AF ? 11'h000 : per_cnt + 11'h001);
            hi_mod  <= $rose(pwm_out) ? 3'h1 : (hi_mod == 3'h4 ? 3'h0 : hi_mod + 3'h1);
            seen    <= seen | $rose(pwm_out);
        end
    end
    sequence s_bad;
        psel && penable && !mapped;
    endsequence
    sequence s_good;
        psel && penable && mapped;
    endsequence
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_unmapped: assert property (s_bad |-> pslverr)
        else $error("no error on unmapped access");
    chk_err_mapped: assert property (s_good |-> !pslverr)
        else $error("error on mapped access");
    chk_read_zero: assert property (s_bad |-> pwrite || prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    chk_period_align: assert property ($rose(pwm_out) && seen |-> per_cnt == 11'h000)
        else $error("pwm pulse not at period start");
    chk_slot_width: assert property ($fell(pwm_out) |-> hi_mod == 3'h0)
        else $error("pwm high time not whole slots");
    chk_irq_masked: assert property (mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |-> !irq)
        else $error("irq high while masked");
endmodule : fsmc_checker

// ### verif/fsmc_fan_model.sv
// fan model: tach toggles while the drive is on
// assumes pwm_out high = drive on; tach pulled high when off or stalled
`timescale 1ns/100ps
module fsmc_fan_model #(
    parameter int HALF = 10
) (
    input  wire logic pclk,
    input  wire logic pwm_out,
    input  wire logic stall,
    output logic      tach
);
    int cnt = 0;
    initial tach = 1'b1;
    always @(posedge pclk) begin
        if (!pwm_out || stall) begin
            tach <= 1'b1;
            cnt  <= 0;
        end else if (cnt == HALF - 1) begin
            tach <= !tach;
            cnt  <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : fsmc_fan_model

// ### verif/fan_speed_mode_control_test.sv
// testbench: registers, duty codes, interrupt, auto and rpm modes
// assumes fsmc_top, fan model and checker; pclk 125 MHz
`timescale 1ns/100ps
module fan_speed_mode_control_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tach;
    logic        pwm_out;
    logic        fan_fail;
    logic        irq;
    logic        stall = 1'b0;
    logic [31:0] rd;
    logic        err;
    int          miscompares = 0;
    int          checks = 0;
    int          high;
    int          h1;
    logic [11:0] ra [7] = '{12'h000, 12'h040, 12'h080, 12'h088, 12'h08C, 12'h0C0, 12'h0E0};
    logic [7:0]  rv [7] = '{8'h00, 8'hFF, 8'h40, 8'h0F, 8'h10, 8'h00, 8'h00};
    fsmc_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fan_speed_sense_input(tach), .pwm_out(pwm_out), .fan_fail(fan_fail), .irq(irq)
    );
    fsmc_fan_model i_fan (.pclk(pclk), .pwm_out(pwm_out), .stall(stall), .tach(tach));
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic duty(input int wait_n);
        repeat (wait_n) @(posedge pclk);
        high = 0;
        repeat (1200) @(posedge pclk) high += (pwm_out === 1'b1);
    endtask : duty
    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        forever #4 pclk = ~pclk;
    end
    initial begin
        #720000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(0, ra[i], 0);
            check(rd, rv[i]);
        end
        apb(1, 12'h040, 32'hFFFF_FF43);
        apb(0, 12'h040, 0);
        check(rd, 32'h43);
        apb(1, 12'h0FC, 32'h55);
        check(err, 1);
        apb(0, 12'h0FC, 0);
        check(rd, 0);
        $display("test registers done");
        for (int c = 0; c < 16; c++) begin
            apb(1, 12'h088, c);
            duty(1300);
            check(high, c * 80);
        end
        $display("test duty codes done");
        repeat (200) @(posedge pclk);
        apb(0, 12'h0D0, 0);
        check(rd, 32'h2);
        check(irq, 0);
        apb(0, 12'h020, 0);
        check(rd < 2, 1);
        apb(1, 12'h0E0, 2);
        repeat (2) @(posedge pclk);
        check(irq, 1);
        stall <= 1'b1;
        repeat (200) @(posedge pclk);
        apb(1, 12'h0D0, 2);
        apb(0, 12'h0D0, 0);
        check(rd, 0);
        check(irq, 0);
        check(fan_fail, 0);
        stall <= 1'b0;
        $display("test interrupt done");
        apb(1, 12'h0C0, 32'h78);
        apb(1, 12'h000, 32'h80);
        duty(1300);
        check(high, 600);
        apb(1, 12'h000, 32'h20);
        apb(1, 12'h040, 32'h80);
        duty(1300);
        h1 = high;
        duty(20000);
        check(high < h1, 1);
        $display("test modes done");
        wrap_up();
    end
endmodule : fan_speed_mode_control_test
bind fsmc_top fsmc_checker i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fan_speed_sense_input(fan_speed_sense_input), .pwm_out(pwm_out), .fan_fail(fan_fail), .irq(irq)
);
